// [tpq_defines.svh]
`ifndef TPQ_DEFINES_SVH
`define TPQ_DEFINES_SVH

`define TPQ_OFS_TX_CONTROL 8'h70
`define TPQ_OFS_TX_FRAME_STATUS 8'h72
`define TPQ_OFS_TX_FREE_MEMORY 8'h78
`define TPQ_OFS_TX_QUEUE_COMMAND 8'h80
`define TPQ_OFS_RX_QUEUE_COMMAND 8'h82
`define TPQ_OFS_TX_DATA_POINTER 8'h84
`define TPQ_OFS_INTERRUPT_ENABLE 8'h90
`define TPQ_OFS_INTERRUPT_STATUS 8'h92
`define TPQ_OFS_TX_SPACE_REQUEST 8'h9E
`define TPQ_OFS_ENDIAN 8'hF0

`define TPQ_MEM_BYTES 13'd6144
`define TPQ_MEM_WORDS 3072
`define TPQ_MAX_DATA 11'd2000

`define TPQ_CW_IOC 15
`define TPQ_TXC_FLOW 3
`define TPQ_TXC_PAD 2
`define TPQ_TXC_CRC 1
`define TPQ_TXC_EN 0
`define TPQ_QC_MANUAL 0
`define TPQ_QC_SPACE 1
`define TPQ_QC_AUTO 2
`define TPQ_RQC_XFER 3
`define TPQ_PTR_AUTOINC 14
`define TPQ_IRQ_TXDONE 14
`define TPQ_IRQ_SPACE 6

`define TPQ_CTRL_RESET 16'h0000
`define TPQ_CTRL_MASK 16'h01EF

`endif

// [tpq_pkg.sv]
package tpq_pkg;
    typedef enum logic [3:0] {
        TPQ_IDLE = 4'b0001,
        TPQ_HEAD = 4'b0010,
        TPQ_SEND = 4'b0100,
        TPQ_DONE = 4'b1000
    } tpq_state_t;
endpackage

// [tpq_transmit_packet_queue.sv]
`timescale 1ns/100ps
`include "tpq_defines.svh"
module tpq_transmit_packet_queue
    import tpq_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic cmd,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] shared_bus_in,
    output logic [15:0] shared_bus_out,
    output logic shared_bus_oe,
    output logic interrupt_out_n,
    output logic [7:0] mac_data,
    output logic mac_valid,
    output logic mac_last,
    input wire logic mac_ready,
    input wire logic mac_done,
    output logic [8:0] mac_options
);
    localparam int AW = 12;
    logic [15:0] mem [0:`TPQ_MEM_WORDS-1];
    logic [7:0] addr_q;
    logic [15:0] tx_control_q;
    logic [15:0] tx_frame_status_q;
    logic [2:0] qcmd_q;
    logic [15:0] rx_queue_command_q;
    logic [15:0] tx_data_pointer_q;
    logic [15:0] interrupt_enable_q;
    logic [15:0] interrupt_status_q;
    logic [15:0] tx_space_request_q;
    logic big_endian_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] commit_ptr_q;
    logic [AW-1:0] frame_words_q;
    logic [10:0] remain_q;
    logic byte_sel_q;
    logic [15:0] word_q;
    logic ioc_q;
    logic [5:0] fid_q;
    logic wr_q;
    tpq_state_t state_q;

    logic wr_fall;
    logic wr_data;
    logic data_wr;
    logic commit_now;
    logic frame_done;
    logic [15:0] wval;
    logic [15:0] cnt_sw;
    logic [12:0] free_now;
    logic space_hit;
    logic [AW-1:0] head_words;
    logic [15:0] rd_word;

    // Strobes sampled in the clock domain; act once per strobe edge
    assign wr_fall = !cs_n && !wr_n && wr_q;
    assign wr_data = wr_fall && !cmd;
    assign data_wr = wr_data && addr_q == 8'h00
        && rx_queue_command_q[`TPQ_RQC_XFER];
    assign wval = shared_bus_in;
    // Commit only a frame whose count word was written since the last commit
    assign commit_now = wr_data && frame_words_q != '0
        && ((addr_q == `TPQ_OFS_TX_QUEUE_COMMAND
        && wval[`TPQ_QC_MANUAL] && !qcmd_q[`TPQ_QC_MANUAL])
        || (addr_q == `TPQ_OFS_TX_DATA_POINTER && qcmd_q[`TPQ_QC_AUTO]
        && tx_data_pointer_q[10:0] != 11'd0));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= 1'b1;
        end
        else
        begin
            wr_q <= cs_n | wr_n;
        end
    end

    // Address phase; data register uses address 0
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            addr_q <= 8'h00;
        else if (wr_fall && cmd)
            addr_q <= {wval[7:2], wval[15], 1'b0}; // Upper byte enables pick odd word
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_control_q <= `TPQ_CTRL_RESET;
            rx_queue_command_q <= 16'h0000;
            tx_data_pointer_q <= 16'h0000;
            interrupt_enable_q <= 16'h0000;
            tx_space_request_q <= 16'h0000;
            big_endian_q <= 1'b0;
        end
        else
        begin
            if (wr_data)
            begin
                case (addr_q)
                    `TPQ_OFS_TX_CONTROL: tx_control_q <= wval & `TPQ_CTRL_MASK;
                    `TPQ_OFS_RX_QUEUE_COMMAND: rx_queue_command_q <= wval;
                    `TPQ_OFS_TX_DATA_POINTER: tx_data_pointer_q <= wval;
                    `TPQ_OFS_INTERRUPT_ENABLE: interrupt_enable_q <= wval;
                    `TPQ_OFS_TX_SPACE_REQUEST: tx_space_request_q <= wval;
                    `TPQ_OFS_ENDIAN: big_endian_q <= wval[0];
                    default: ;
                endcase
            end
            if (data_wr && tx_data_pointer_q[`TPQ_PTR_AUTOINC])
                tx_data_pointer_q[10:0] <= tx_data_pointer_q[10:0] + 11'd2;
        end
    end

    // Control and count words are byte-swapped when big-endian
    assign cnt_sw = big_endian_q ? {wval[7:0], wval[15:8]} : wval;

    // Host writes land at commit point plus data pointer
    always_ff @(posedge clock)
    begin
        if (data_wr)
            mem[commit_ptr_q + AW'(tx_data_pointer_q[11:1])] <=
                (tx_data_pointer_q[10:1] < 10'd2) ? cnt_sw : wval;
    end

    // Count word tracks the prepared frame's size in words
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            frame_words_q <= '0;
        else if (commit_now)
            frame_words_q <= '0;
        else if (data_wr && tx_data_pointer_q[10:1] == 10'd1)
            frame_words_q <= AW'((cnt_sw[10:0] + 12'd7) >> 2) << 1;
    end


    // Enqueue: manual once, or automatically at each reset of the data pointer
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            qcmd_q <= 3'b000;
            commit_ptr_q <= '0;
        end
        else
        begin
            if (wr_data && addr_q == `TPQ_OFS_TX_QUEUE_COMMAND)
            begin
                qcmd_q <= qcmd_q | wval[2:0];
                qcmd_q[`TPQ_QC_AUTO] <= wval[`TPQ_QC_AUTO];
            end
            if (commit_now)
                commit_ptr_q <= commit_ptr_q + frame_words_q;
            if (frame_done)
                qcmd_q[`TPQ_QC_MANUAL] <= 1'b0;
            if (qcmd_q[`TPQ_QC_SPACE] && space_hit)
                qcmd_q[`TPQ_QC_SPACE] <= 1'b0;
        end
    end

    // Free space: occupied region is rd_ptr up to commit_ptr, header included
    assign head_words = commit_ptr_q - rd_ptr_q;
    assign free_now = `TPQ_MEM_BYTES - (13'(head_words) << 1);
    // Request is in double words, free space in bytes
    assign space_hit = {5'b00000, free_now} >= {tx_space_request_q, 2'b00};

    // MAC side: reads words from rd_ptr, sends bytes low first
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= TPQ_IDLE;
            rd_ptr_q <= '0;
            remain_q <= 11'd0;
            byte_sel_q <= 1'b0;
            word_q <= 16'h0000;
            ioc_q <= 1'b0;
            fid_q <= 6'd0;
        end
        else
        begin
            case (state_q)
                TPQ_IDLE:
                    if (rd_ptr_q != commit_ptr_q && tx_control_q[`TPQ_TXC_EN])
                    begin
                        ioc_q <= mem[rd_ptr_q][`TPQ_CW_IOC];
                        fid_q <= mem[rd_ptr_q][5:0];
                        state_q <= TPQ_HEAD;
                    end
                TPQ_HEAD:
                begin
                    remain_q <= mem[rd_ptr_q + AW'(1)][10:0];
                    word_q <= mem[rd_ptr_q + AW'(2)];
                    byte_sel_q <= 1'b0;
                    state_q <= TPQ_SEND;
                end
                TPQ_SEND:
                    if (mac_ready)
                    begin
                        remain_q <= remain_q - 11'd1;
                        byte_sel_q <= !byte_sel_q;
                        if (byte_sel_q)
                            word_q <= mem[rd_ptr_q + AW'(2)
                                + AW'((mem[rd_ptr_q + AW'(1)][10:0] - remain_q + 11'd1) >> 1)];
                        if (remain_q == 11'd1)
                            state_q <= TPQ_DONE;
                    end
                TPQ_DONE:
                    if (mac_done)
                    begin
                        // Size from the sent frame's own count, not the one being prepared
                        rd_ptr_q <= rd_ptr_q
                            + (AW'((mem[rd_ptr_q + AW'(1)][10:0] + 12'd7) >> 2) << 1);
                        state_q <= TPQ_IDLE;
                    end
                default: state_q <= TPQ_IDLE;
            endcase
        end
    end

    assign frame_done = state_q == TPQ_DONE && mac_done;
    assign mac_valid = state_q == TPQ_SEND;
    assign mac_last = state_q == TPQ_SEND && remain_q == 11'd1;
    assign mac_data = byte_sel_q ? word_q[15:8] : word_q[7:0];
    assign mac_options = {tx_control_q[8:5], tx_control_q[3:0], 1'b0};

    // Status of the frame currently on the MAC
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_frame_status_q <= 16'h0000;
        else if (state_q == TPQ_HEAD)
            tx_frame_status_q <= {10'h000, fid_q};
    end

    // Set beats clear in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            interrupt_status_q <= 16'h0000;
        else
        begin
            if (wr_data && addr_q == `TPQ_OFS_INTERRUPT_STATUS)
                interrupt_status_q <= interrupt_status_q & ~wval;
            if (frame_done && ioc_q)
                interrupt_status_q[`TPQ_IRQ_TXDONE] <= 1'b1;
            if (qcmd_q[`TPQ_QC_SPACE] && space_hit)
                interrupt_status_q[`TPQ_IRQ_SPACE] <= 1'b1;
        end
    end

    assign interrupt_out_n = !(|(interrupt_status_q & interrupt_enable_q));

    always_comb
    begin
        case (addr_q)
            `TPQ_OFS_TX_CONTROL: rd_word = tx_control_q;
            `TPQ_OFS_TX_FRAME_STATUS: rd_word = tx_frame_status_q;
            `TPQ_OFS_TX_FREE_MEMORY: rd_word = {3'b000, free_now};
            `TPQ_OFS_TX_QUEUE_COMMAND: rd_word = {13'h0000, qcmd_q};
            `TPQ_OFS_RX_QUEUE_COMMAND: rd_word = rx_queue_command_q;
            `TPQ_OFS_TX_DATA_POINTER: rd_word = tx_data_pointer_q;
            `TPQ_OFS_INTERRUPT_ENABLE: rd_word = interrupt_enable_q;
            `TPQ_OFS_INTERRUPT_STATUS: rd_word = interrupt_status_q;
            `TPQ_OFS_TX_SPACE_REQUEST: rd_word = tx_space_request_q;
            `TPQ_OFS_ENDIAN: rd_word = {15'h0000, big_endian_q};
            default: rd_word = 16'h0000;
        endcase
    end

    // Read data held from a flip-flop while the strobe is low
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            shared_bus_out <= 16'h0000;
        else if (!cs_n && !rd_n)
            shared_bus_out <= cmd ? {8'h00, addr_q} : rd_word;
    end

    assign shared_bus_oe = !cs_n && !rd_n;
endmodule

// [tpq_checker_assertions.sv]
`timescale 1ns/100ps
module tpq_checker_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic shared_bus_oe,
    input wire logic interrupt_out_n,
    input wire logic [7:0] mac_data,
    input wire logic mac_valid,
    input wire logic mac_last,
    input wire logic mac_ready,
    input wire logic mac_done,
    input wire logic [8:0] mac_options
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence byte_stall;
        mac_valid && !mac_ready;
    endsequence
    sequence recent_wr;
        $past(!cs_n && !wr_n) || $past(!cs_n && !wr_n, 2) || $past(!cs_n && !wr_n, 3);
    endsequence
    sequence recent_done;
        $past(mac_done) || $past(mac_done, 2) || $past(mac_done, 3);
    endsequence
    bus_drive_a: assert property (shared_bus_oe == (!cs_n && !rd_n))
        else $error("read data driven outside a read");
    byte_hold_a: assert property (byte_stall |=> mac_valid && $stable(mac_data))
        else $error("byte changed while stalled");
    last_valid_a: assert property (mac_last |-> mac_valid)
        else $error("frame end without a byte");
    opt_spare_a: assert property (mac_options[0] == 1'b0)
        else $error("spare option bit set");
    opt_cause_a: assert property ($changed(mac_options) |-> recent_wr)
        else $error("options changed without a write");
    send_enable_a: assert property ($rose(mac_valid) |-> mac_options[1])
        else $error("frame started while transmit disabled");
    irq_raise_a: assert property ($fell(interrupt_out_n) |-> recent_wr or recent_done)
        else $error("interrupt without a cause");
    irq_clear_a: assert property ($rose(interrupt_out_n) |-> recent_wr)
        else $error("interrupt cleared without a write");
    reset_quiet_a: assert property ($rose(rst_n) |-> interrupt_out_n && !mac_valid)
        else $error("outputs active after reset");
endmodule

bind tpq_transmit_packet_queue tpq_checker_assertions chk_u (.*);

// [tpq_mac_model.sv]
`timescale 1ns/100ps
module tpq_mac_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] mac_data,
    input wire logic mac_valid,
    input wire logic mac_last,
    output logic mac_ready,
    output logic mac_done
);
    logic [7:0] got [0:15];
    int n_got;
    int wait_cnt;
    // Stalls on alternate cycles so held bytes get exercised
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mac_ready <= 1'b0;
            mac_done <= 1'b0;
            n_got <= 0;
            wait_cnt <= 0;
        end
        else
        begin
            mac_ready <= !mac_ready;
            mac_done <= (wait_cnt == 1);
            if (wait_cnt > 0)
                wait_cnt <= wait_cnt - 1;
            if (mac_valid && mac_ready)
            begin
                got[n_got[3:0]] <= mac_data;
                n_got <= n_got + 1;
                if (mac_last)
                    wait_cnt <= 6;
            end
        end
    end
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
`include "tpq_defines.svh"
module tb_top;
    logic clock, rst_n, cs_n, cmd, rd_n, wr_n, mac_ready, mac_done, shared_bus_oe;
    logic interrupt_out_n, mac_valid, mac_last;
    logic [15:0] shared_bus_in, shared_bus_out, v;
    logic [7:0] mac_data;
    logic [8:0] mac_options;
    int error_cnt, n_checks, i;
    logic [7:0] exp_b [0:9] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
        8'hAA, 8'hBB, 8'hCC, 8'hDD};
    tpq_transmit_packet_queue dut_u (
        .clock(clock),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .cmd(cmd),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .shared_bus_in(shared_bus_in),
        .shared_bus_out(shared_bus_out),
        .shared_bus_oe(shared_bus_oe),
        .interrupt_out_n(interrupt_out_n),
        .mac_data(mac_data),
        .mac_valid(mac_valid),
        .mac_last(mac_last),
        .mac_ready(mac_ready),
        .mac_done(mac_done),
        .mac_options(mac_options)
    );
    tpq_mac_model mac_u (
        .clock(clock),
        .rst_n(rst_n),
        .mac_data(mac_data),
        .mac_valid(mac_valid),
        .mac_last(mac_last),
        .mac_ready(mac_ready),
        .mac_done(mac_done)
    );
    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write strobe held two clocks so the sampled falling edge is seen
    task automatic strobe(input logic c, input logic [15:0] d);
        @(posedge clock);
        #10;
        cs_n = 1'b0;
        cmd = c;
        shared_bus_in = d;
        wr_n = 1'b0;
        repeat (2) @(posedge clock);
        #10;
        wr_n = 1'b1;
        cs_n = 1'b1;
    endtask
    task automatic set_addr(input logic [7:0] a);
        strobe(1'b1, {(a[1] ? 4'hC : 4'h3), 4'h0, a});
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        set_addr(a);
        strobe(1'b0, d);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        set_addr(a);
        @(posedge clock);
        #10;
        cs_n = 1'b0;
        cmd = 1'b0;
        rd_n = 1'b0;
        repeat (2) @(posedge clock);
        #10;
        d = shared_bus_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        #2000000;
        error_cnt++;
        summarize();
    end
    initial
    begin
        {cs_n, rd_n, wr_n, cmd, rst_n} = 5'b11100;
        shared_bus_in = 16'h0000;
        repeat (20) @(posedge clock);
        #10;
        rst_n = 1'b1;
        repeat (2) @(posedge clock);
        rd_reg(`TPQ_OFS_TX_FREE_MEMORY, v);
        chk(v, 16'h1800);
        rd_reg(8'h60, v);
        chk(v, 16'h0000);
        wr_reg(`TPQ_OFS_TX_CONTROL, 16'hFFFF);
        rd_reg(`TPQ_OFS_TX_CONTROL, v);
        chk(v, 16'h01EF);
        chk({7'h00, mac_options}, 16'h01FE);
        wr_reg(`TPQ_OFS_TX_CONTROL, 16'h0001);
        wr_reg(`TPQ_OFS_INTERRUPT_ENABLE, 16'h4040);
        wr_reg(`TPQ_OFS_RX_QUEUE_COMMAND, 16'h0008);
        wr_reg(`TPQ_OFS_TX_DATA_POINTER, 16'h4000);
        set_addr(8'h00);
        strobe(1'b0, 16'h8015);
        strobe(1'b0, 16'h0006);
        strobe(1'b0, 16'h2211);
        strobe(1'b0, 16'h4433);
        strobe(1'b0, 16'h6655);
        rd_reg(`TPQ_OFS_TX_DATA_POINTER, v);
        chk(v, 16'h400A);
        wr_reg(`TPQ_OFS_TX_QUEUE_COMMAND, 16'h0001);
        // Queued frame holds header plus data, padded to a double word
        rd_reg(`TPQ_OFS_TX_FREE_MEMORY, v);
        chk(v, 16'h17F4);
        v = 16'h0001;
        for (i = 0; i < 60 && v[0] !== 1'b0; i++)
            rd_reg(`TPQ_OFS_TX_QUEUE_COMMAND, v);
        chk(v & 16'h0001, 16'h0000);
        chk({15'h0, interrupt_out_n}, 16'h0000);
        rd_reg(`TPQ_OFS_TX_FRAME_STATUS, v);
        chk(v & 16'h003F, 16'h0015);
        rd_reg(`TPQ_OFS_TX_FREE_MEMORY, v);
        chk(v, 16'h1800);
        wr_reg(`TPQ_OFS_INTERRUPT_STATUS, 16'hFFFF);
        chk({15'h0, interrupt_out_n}, 16'h0001);
        // Big-endian headers; unswapped they would read as 512-byte frames
        wr_reg(`TPQ_OFS_ENDIAN, 16'h0001);
        wr_reg(`TPQ_OFS_TX_QUEUE_COMMAND, 16'h0004);
        wr_reg(`TPQ_OFS_TX_DATA_POINTER, 16'h4000);
        set_addr(8'h00);
        strobe(1'b0, 16'h0500);
        strobe(1'b0, 16'h0200);
        strobe(1'b0, 16'hBBAA);
        wr_reg(`TPQ_OFS_TX_DATA_POINTER, 16'h4000);
        set_addr(8'h00);
        strobe(1'b0, 16'h0600);
        strobe(1'b0, 16'h0200);
        strobe(1'b0, 16'hDDCC);
        wr_reg(`TPQ_OFS_TX_DATA_POINTER, 16'h4000);
        for (i = 0; i < 400 && mac_u.n_got < 10; i++)
            @(posedge clock);
        chk(16'(mac_u.n_got), 16'd10);
        for (i = 0; i < 10; i++)
            chk({8'h00, mac_u.got[i]}, {8'h00, exp_b[i]});
        repeat (10) @(posedge clock);
        rd_reg(`TPQ_OFS_TX_FRAME_STATUS, v);
        chk(v & 16'h003F, 16'h0006);
        chk({15'h0, interrupt_out_n}, 16'h0001);
        wr_reg(`TPQ_OFS_TX_SPACE_REQUEST, 16'h0010);
        wr_reg(`TPQ_OFS_TX_QUEUE_COMMAND, 16'h0006);
        repeat (4) @(posedge clock);
        chk({15'h0, interrupt_out_n}, 16'h0000);
        rd_reg(`TPQ_OFS_TX_QUEUE_COMMAND, v);
        chk(v & 16'h0002, 16'h0000);
        wr_reg(`TPQ_OFS_INTERRUPT_STATUS, 16'h0040);
        chk({15'h0, interrupt_out_n}, 16'h0001);
        wr_reg(`TPQ_OFS_INTERRUPT_ENABLE, 16'h4000);
        wr_reg(`TPQ_OFS_TX_QUEUE_COMMAND, 16'h0006);
        repeat (4) @(posedge clock);
        rd_reg(`TPQ_OFS_INTERRUPT_STATUS, v);
        chk(v & 16'h0040, 16'h0040);
        chk({15'h0, interrupt_out_n}, 16'h0001);
        summarize();
    end
endmodule
